// ===== src/cis_core.sv
// Instruction semantics unit with APB register access
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`include "cis_params.svh"
module cis_core #(
   parameter int AW = 16
) (
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RESET,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   output logic             O_BUSY
);
   cis_pkg::cis_state_type state_reg;
   cis_pkg::cis_ps_type    ps_reg;
   cis_pkg::cis_op_type    op;
   logic [15:0] a_reg, b_reg, x_reg, y_reg, s_reg, dpr_reg;
   logic [15:0] maddr_reg, cyc_reg, res_cyc_reg;
   logic [7:0]  pg_reg, dt_reg, mask_reg;
   logic [2:0]  idx_reg, cfg_reg;
   logic [1:0]  q_fill_reg, len, stall;
   logic [3:0]  extra;
   logic        dp_fast_reg, bra_fault_reg, m0_reg, op_dn_reg;
   logic [7:0]  mem [0:(1<<AW)-1];
   logic        wr_en, go, w16, sub, slow;
   logic [15:0] opb, res, cnt, mv_x, mv_y;
   logic [16:0] sum, dec;
   logic        ar_c, ar_z, ar_n, ar_v;
   logic [15:0] push_val, pull_val;
   logic        push_wide;
   logic [15:0] s_m1, s_p1, s_p2, x_p1;
   logic        we0, we1;
   logic [15:0] wa0, wa1;
   logic [7:0]  wd0, wd1;

   // Decimal add or subtract, one nibble at a time
   function automatic logic [16:0] dec_op(input logic [15:0] a, input logic [15:0] b,
                                          input logic cin, input logic sb, input logic wd);
      logic [16:0] r;
      logic        k;
      logic        c8;
      logic [4:0]  t;
      r = 17'h00000;
      k = cin;
      c8 = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (sb) begin
            t = {1'b0, a[4*i+:4]} - {1'b0, b[4*i+:4]} - {4'h0, ~k};
            k = ~t[4];
            if (t[4]) begin
               t = t + 5'h0A;
            end
         end else begin
            t = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, k};
            k = (t > 5'h09);
            if (k) begin
               t = t + 5'h06;
            end
         end
         r[4*i+:4] = t[3:0];
         if (i == 1) begin
            c8 = k;
         end
      end
      r[16] = wd ? k : c8;
      return r;
   endfunction

   // Step a move pointer; an 8-bit index keeps its bank byte
   function automatic logic [15:0] step(input logic [15:0] v, input logic dn,
                                        input logic x8);
      logic [15:0] nv;
      nv = dn ? v - 16'h0001 : v + 16'h0001;
      return x8 ? {v[15:8], nv[7:0]} : nv;
   endfunction

   // Width of a stacked register, by mask position
   function automatic logic reg_wide(input logic [2:0] i, input logic m,
                                     input logic x);
      case (i)
         3'h0, 3'h1: reg_wide = ~m;
         3'h2, 3'h3: reg_wide = ~x;
         3'h4:       reg_wide = 1'b1;
         default:    reg_wide = 1'b0;
      endcase
   endfunction

   // Bus request decode
   assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
   assign op    = cis_pkg::cis_op_type'(I_PWDATA[3:0]);
   assign go    = wr_en && (I_PADDR == `CIS_OFF_CMD) && (state_reg == cis_pkg::ST_IDLE);
   assign w16   = ~ps_reg.m;
   assign sub   = (op == cis_pkg::OP_SBC);
   assign s_m1  = s_reg - 16'h0001;
   assign s_p1  = s_reg + 16'h0001;
   assign s_p2  = s_reg + 16'h0002;
   assign x_p1  = x_reg + 16'h0001;

   // Arithmetic: binary flags, or decimal result when D is set
   always_comb begin
      opb = sub ? ~b_reg : b_reg;
      sum = w16 ? {1'b0, a_reg} + {1'b0, opb} + {16'h0000, ps_reg.c}
                : {9'h000, a_reg[7:0]} + {9'h000, opb[7:0]} + {16'h0000, ps_reg.c};
      dec = dec_op(a_reg, b_reg, ps_reg.c, sub, w16);
      res = ps_reg.d ? dec[15:0] : sum[15:0];
      if (!w16) begin
         res = {a_reg[15:8], res[7:0]};
      end
      ar_c = ps_reg.d ? dec[16] : (w16 ? sum[16] : sum[8]);
      ar_z = w16 ? (res == 16'h0000) : (res[7:0] == 8'h00);
      ar_n = w16 ? res[15] : res[7];
      ar_v = w16 ? (a_reg[15] == opb[15]) && (res[15] != a_reg[15])
                 : (a_reg[7] == opb[7]) && (res[7] != a_reg[7]);
   end

   // Issue cost: queue refill, fetch source, direct page, alignment
   always_comb begin
      case (op)
         cis_pkg::OP_ADC, cis_pkg::OP_SBC: len = ps_reg.m ? 2'h2 : 2'h3;
         cis_pkg::OP_BRAL, cis_pkg::OP_MVN, cis_pkg::OP_MVP: len = 2'h3;
         cis_pkg::OP_PSH, cis_pkg::OP_PUL, cis_pkg::OP_BRK, cis_pkg::OP_DPOP: len = 2'h2;
         default: len = 2'h1;
      endcase
      stall = (len > q_fill_reg) ? len - q_fill_reg : 2'h0;
      // full speed on internal fetch, or on external fetch with wide bus and no wait
      slow = cfg_reg[`CIS_CFG_EXT] & ~(cfg_reg[`CIS_CFG_BUS16] & ~cfg_reg[`CIS_CFG_WAIT]);
      extra = {2'h0, stall} + (slow ? {2'h0, len} : 4'h0);
      // non-zero base low byte, as seen at the last DPR write or PLD, costs one cycle
      if (op == cis_pkg::OP_DPOP && !dp_fast_reg) begin
         extra = extra + 4'h1;
      end
      if (op == cis_pkg::OP_LD16 && x_reg[0]) begin
         extra = extra + 4'h1;
      end
   end

   // Stack and move data paths
   always_comb begin
      case (idx_reg)
         3'h0:    push_val = a_reg;
         3'h1:    push_val = b_reg;
         3'h2:    push_val = x_reg;
         3'h3:    push_val = y_reg;
         3'h4:    push_val = dpr_reg;
         3'h5:    push_val = {8'h00, dt_reg};
         3'h6:    push_val = {8'h00, pg_reg};
         default: push_val = {8'h00, ps_reg};
      endcase
      push_wide = reg_wide(idx_reg, ps_reg.m, ps_reg.x);
      pull_val = {mem[s_p2[AW-1:0]], mem[s_p1[AW-1:0]]};
      cnt = ps_reg.m ? {8'h00, a_reg[7:0]} : a_reg;
      mv_x = step(x_reg, state_reg == cis_pkg::ST_MOVE && op_dn_reg, ps_reg.x);
      mv_y = step(y_reg, state_reg == cis_pkg::ST_MOVE && op_dn_reg, ps_reg.x);
   end

   // Memory write ports
   always_comb begin
      we0 = 1'b0;
      we1 = 1'b0;
      wa0 = maddr_reg;
      wa1 = s_m1;
      wd0 = I_PWDATA[7:0];
      wd1 = push_val[7:0];
      if (state_reg == cis_pkg::ST_MOVE) begin
         we0 = 1'b1;
         wa0 = y_reg;
         wd0 = mem[x_reg[AW-1:0]];
      end else if (state_reg == cis_pkg::ST_PUSH && mask_reg[idx_reg]) begin
         we0 = 1'b1;
         wa0 = s_reg;
         wd0 = push_wide ? push_val[15:8] : push_val[7:0];
         we1 = push_wide;
      end else if (wr_en && I_PADDR == `CIS_OFF_MDATA && state_reg == cis_pkg::ST_IDLE) begin
         we0 = 1'b1;
      end
   end

   // Memory array
   always_ff @(posedge I_SYS_CLK) begin
      if (we0) begin
         mem[wa0[AW-1:0]] <= wd0;
      end
      if (we1) begin
         mem[wa1[AW-1:0]] <= wd1;
      end
   end

   // APB answer: ready in the first access cycle
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA  <= 32'h00000000;
      end else begin
         O_PREADY  <= I_PSEL & ~I_PENABLE;
         O_PSLVERR <= 1'b0;
         if (I_PSEL & ~I_PENABLE) begin
            case (I_PADDR)
               `CIS_OFF_CMD:   O_PRDATA <= {31'h0, O_BUSY};
               `CIS_OFF_A:     O_PRDATA <= {16'h0, a_reg};
               `CIS_OFF_B:     O_PRDATA <= {16'h0, b_reg};
               `CIS_OFF_X:     O_PRDATA <= {16'h0, x_reg};
               `CIS_OFF_Y:     O_PRDATA <= {16'h0, y_reg};
               `CIS_OFF_S:     O_PRDATA <= {16'h0, s_reg};
               `CIS_OFF_DPR:   O_PRDATA <= {16'h0, dpr_reg};
               `CIS_OFF_BANK:  O_PRDATA <= {16'h0, dt_reg, pg_reg};
               `CIS_OFF_PS:    O_PRDATA <= {24'h0, ps_reg};
               `CIS_OFF_MADDR: O_PRDATA <= {16'h0, maddr_reg};
               `CIS_OFF_MDATA: O_PRDATA <= {24'h0, mem[maddr_reg[AW-1:0]]};
               `CIS_OFF_STAT:  O_PRDATA <= {11'h0, O_BUSY, dp_fast_reg, bra_fault_reg,
                                            ~ps_reg.x, ~ps_reg.m, res_cyc_reg};
               `CIS_OFF_CFG:   O_PRDATA <= {29'h0, cfg_reg};
               default: begin
                  O_PRDATA  <= 32'h00000000;
                  O_PSLVERR <= 1'b1;
               end
            endcase
         end
      end
   end

   // Prefetch queue fill and cycle counter
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         q_fill_reg <= 2'h0;
         cyc_reg    <= 16'h0000;
      end else if (go) begin
         q_fill_reg <= (q_fill_reg >= len) ? q_fill_reg - len : 2'h0;
         cyc_reg    <= 16'h0001 + {12'h000, extra};
      end else if (state_reg != cis_pkg::ST_IDLE) begin
         cyc_reg    <= cyc_reg + 16'h0001;
      end else if (q_fill_reg != `CIS_QUEUE_DEPTH) begin
         q_fill_reg <= q_fill_reg + 2'h1;
      end
   end

   // Core registers and sequencer; stack pointer is left unreset
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         state_reg <= cis_pkg::ST_IDLE;
         ps_reg <= `CIS_PS_RESET;
         {a_reg, b_reg, x_reg, y_reg, dpr_reg, maddr_reg} <= '0;
         {pg_reg, dt_reg, mask_reg} <= '0;
         {idx_reg, cfg_reg, m0_reg, op_dn_reg} <= '0;
         {res_cyc_reg, dp_fast_reg, bra_fault_reg} <= {16'h0000, 1'b1, 1'b0};
         O_BUSY <= 1'b0;
      end else begin
         if (wr_en && state_reg == cis_pkg::ST_IDLE) begin
            case (I_PADDR)
               `CIS_OFF_A:     a_reg <= I_PWDATA[15:0];
               `CIS_OFF_B:     b_reg <= I_PWDATA[15:0];
               `CIS_OFF_X:     x_reg <= I_PWDATA[15:0];
               `CIS_OFF_Y:     y_reg <= I_PWDATA[15:0];
               // software must load before stack use
               `CIS_OFF_S:     s_reg <= I_PWDATA[15:0];
               `CIS_OFF_BANK:  {dt_reg, pg_reg} <= I_PWDATA[15:0];
               `CIS_OFF_PS:    ps_reg <= I_PWDATA[7:0];
               `CIS_OFF_MADDR: maddr_reg <= I_PWDATA[15:0];
               `CIS_OFF_CFG:   cfg_reg <= I_PWDATA[2:0];
               `CIS_OFF_DPR: begin
                  dpr_reg     <= I_PWDATA[15:0];
                  dp_fast_reg <= (I_PWDATA[7:0] == 8'h00);
               end
               default: ;
            endcase
         end
         if (go) begin
            res_cyc_reg <= 16'h0001 + {12'h000, extra};
            // decimal path only on add or subtract
            if (op == cis_pkg::OP_ADC || op == cis_pkg::OP_SBC) begin
               a_reg    <= res;
               ps_reg.c <= ar_c;
               if (!ps_reg.d || sub) begin
                  ps_reg.z <= ar_z;
               end
               // decimal leaves N and V alone
               if (!ps_reg.d) begin
                  ps_reg.n <= ar_n;
                  ps_reg.v <= ar_v;
               end
            end
            case (op)
               cis_pkg::OP_PSH: begin
                  mask_reg  <= I_PWDATA[15:8];
                  idx_reg   <= 3'h7;
                  state_reg <= cis_pkg::ST_PUSH;
                  O_BUSY    <= 1'b1;
               end
               cis_pkg::OP_PUL: begin
                  mask_reg  <= I_PWDATA[15:8];
                  idx_reg   <= 3'h0;
                  m0_reg    <= ps_reg.m;
                  state_reg <= cis_pkg::ST_PULL;
                  O_BUSY    <= 1'b1;
               end
               // single pull of A sets N and Z
               cis_pkg::OP_PLA: begin
                  a_reg    <= ps_reg.m ? {a_reg[15:8], pull_val[7:0]} : pull_val;
                  s_reg    <= ps_reg.m ? s_p1 : s_p2;
                  ps_reg.n <= ps_reg.m ? pull_val[7] : pull_val[15];
                  ps_reg.z <= ps_reg.m ? pull_val[7:0] == 8'h00 : pull_val == 16'h0000;
               end
               cis_pkg::OP_PLD: begin
                  dpr_reg     <= pull_val;
                  s_reg       <= s_p2;
                  dp_fast_reg <= (pull_val[7:0] == 8'h00);
               end
               cis_pkg::OP_MVN, cis_pkg::OP_MVP: begin
                  op_dn_reg <= (op == cis_pkg::OP_MVP);
                  if (cnt != 16'h0000) begin
                     state_reg <= cis_pkg::ST_MOVE;
                     O_BUSY    <= 1'b1;
                  end
               end
               cis_pkg::OP_BRK: ps_reg.i <= 1'b1;
               // long form valid in bank 0 only
               cis_pkg::OP_BRAL: bra_fault_reg <= (pg_reg != 8'h00);
               cis_pkg::OP_LD16: a_reg <= {mem[x_p1[AW-1:0]], mem[x_reg[AW-1:0]]};
               default: ;
            endcase
         end
         case (state_reg)
            cis_pkg::ST_MOVE: begin
               x_reg <= mv_x;
               y_reg <= mv_y;
               a_reg <= ps_reg.m ? {a_reg[15:8], a_reg[7:0] - 8'h01} : a_reg - 16'h0001;
               if (cnt == 16'h0001) begin
                  state_reg   <= cis_pkg::ST_IDLE;
                  O_BUSY      <= 1'b0;
                  res_cyc_reg <= cyc_reg + 16'h0001;
               end
            end
            // bit 6 stacks the program bank
            cis_pkg::ST_PUSH: begin
               if (mask_reg[idx_reg]) begin
                  s_reg <= push_wide ? s_reg - 16'h0002 : s_m1;
               end
               idx_reg <= idx_reg - 3'h1;
               if (idx_reg == 3'h0) begin
                  state_reg   <= cis_pkg::ST_IDLE;
                  O_BUSY      <= 1'b0;
                  res_cyc_reg <= cyc_reg + 16'h0001;
               end
            end
            cis_pkg::ST_PULL: begin
               if (mask_reg[idx_reg]) begin
                  s_reg <= push_wide ? s_p2 : s_p1;
                  case (idx_reg)
                     3'h0: a_reg <= push_wide ? pull_val : {a_reg[15:8], pull_val[7:0]};
                     3'h1: b_reg <= push_wide ? pull_val : {b_reg[15:8], pull_val[7:0]};
                     3'h2: x_reg <= push_wide ? pull_val : {8'h00, pull_val[7:0]};
                     3'h3: y_reg <= push_wide ? pull_val : {8'h00, pull_val[7:0]};
                     3'h4: dpr_reg <= pull_val;
                     3'h5: dt_reg <= pull_val[7:0];
                     3'h6: ;
                     default: begin
                        ps_reg <= pull_val[7:0];
                        if (!m0_reg && pull_val[5] && mask_reg[1]) begin
                           b_reg[15:8] <= 8'h00;
                        end
                     end
                  endcase
               end
               idx_reg <= idx_reg + 3'h1;
               if (idx_reg == 3'h7) begin
                  state_reg   <= cis_pkg::ST_IDLE;
                  O_BUSY      <= 1'b0;
                  res_cyc_reg <= cyc_reg + 16'h0001;
               end
            end
            default: ;
         endcase
      end
   end

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RESET);

   property p_dec_add;
      go && op == cis_pkg::OP_ADC && ps_reg.d |=> $stable({ps_reg.n, ps_reg.v, ps_reg.z});
   endproperty
   a_dec_add: assert property (p_dec_add) else $error("decimal add moved N/V/Z");

   property p_dec_sub;
      go && sub && ps_reg.d |=> $stable({ps_reg.n, ps_reg.v});
   endproperty
   a_dec_sub: assert property (p_dec_sub) else $error("decimal sub moved N/V");

   property p_pul_a_only;
      go && op == cis_pkg::OP_PUL && I_PWDATA[15:8] == 8'h01 |=> $stable(ps_reg)[*8];
   endproperty
   a_pul_a_only: assert property (p_pul_a_only) else $error("pull A changed status");

   property p_pg_kept;
      state_reg == cis_pkg::ST_PULL |=> pg_reg == $past(pg_reg);
   endproperty
   a_pg_kept: assert property (p_pg_kept) else $error("pull restored bank");

   property p_zero_move;
      go && (op == cis_pkg::OP_MVN || op == cis_pkg::OP_MVP) && cnt == 16'h0000
         |=> state_reg == cis_pkg::ST_IDLE && !O_BUSY;
   endproperty
   a_zero_move: assert property (p_zero_move) else $error("zero count moved");

   property p_wrap;
      state_reg == cis_pkg::ST_MOVE && ps_reg.x |=> x_reg[15:8] == $past(x_reg[15:8]);
   endproperty
   a_wrap: assert property (p_wrap) else $error("8-bit index left bank");

   property p_brk;
      go && op == cis_pkg::OP_BRK |=> $stable({a_reg, b_reg, x_reg, y_reg}) && ps_reg.i;
   endproperty
   a_brk: assert property (p_brk) else $error("break byte had effect");

   property p_dp_pul;
      state_reg == cis_pkg::ST_PULL |=> $stable(dp_fast_reg);
   endproperty
   a_dp_pul: assert property (p_dp_pul) else $error("multi pull set saving");

   property p_bral;
      go && op == cis_pkg::OP_BRAL |=> bra_fault_reg == ($past(pg_reg) != 8'h00);
   endproperty
   a_bral: assert property (p_bral) else $error("long branch bank check");

   property p_ready;
      O_PREADY |=> !O_PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("ready held two cycles");

   property p_queue_stall;
      go && (len > q_fill_reg) |=> res_cyc_reg != 16'h0001;
   endproperty
   a_queue_stall: assert property (p_queue_stall) else $error("short queue cost nothing");
endmodule

// ===== src/cis_params.svh
// Register offsets, field positions and reset values of the instruction unit
`ifndef CIS_PARAMS_SVH
`define CIS_PARAMS_SVH
`define CIS_OFF_CMD     8'h00
`define CIS_OFF_A       8'h04
`define CIS_OFF_B       8'h08
`define CIS_OFF_X       8'h0C
`define CIS_OFF_Y       8'h10
`define CIS_OFF_S       8'h14
`define CIS_OFF_DPR     8'h18
`define CIS_OFF_BANK    8'h1C
`define CIS_OFF_PS      8'h20
`define CIS_OFF_MADDR   8'h24
`define CIS_OFF_MDATA   8'h28
`define CIS_OFF_STAT    8'h2C
`define CIS_OFF_CFG     8'h30
`define CIS_PS_RESET    8'h34
`define CIS_PG_PUSH_BIT 6
`define CIS_QUEUE_DEPTH 2'h3
`define CIS_CFG_EXT     0
`define CIS_CFG_BUS16   1
`define CIS_CFG_WAIT    2
`endif

// ===== src/cis_pkg.sv
// Types shared by the instruction unit
package cis_pkg;
   typedef enum logic [3:0] {
      OP_ADC  = 4'h0,
      OP_SBC  = 4'h1,
      OP_PSH  = 4'h2,
      OP_PUL  = 4'h3,
      OP_PLA  = 4'h4,
      OP_PLD  = 4'h5,
      OP_MVN  = 4'h6,
      OP_MVP  = 4'h7,
      OP_BRK  = 4'h8,
      OP_BRAL = 4'h9,
      OP_DPOP = 4'hA,
      OP_LD16 = 4'hB
   } cis_op_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MOVE = 2'b01,
      ST_PUSH = 2'b10,
      ST_PULL = 2'b11
   } cis_state_type;
   // Status word, bit 7 down to bit 0
   typedef struct packed {
      logic n;
      logic v;
      logic m;
      logic x;
      logic d;
      logic i;
      logic z;
      logic c;
   } cis_ps_type;
endpackage

// ===== testbench/tb_top.sv
// Self-checking bench for the instruction semantics unit
`timescale 1ns/100ps
`include "cis_params.svh"
module tb_top;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        busy;
   logic        last_err;
   logic [31:0] rd;
   logic [8:0]  sum;
   logic [7:0]  ra;
   logic [7:0]  rb;
   int          num_errors = 0;
   int          compares = 0;

   // Free-running 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;

   cis_core cis_core_inst (
      .I_SYS_CLK (sys_clk),
      .I_RESET   (reset),
      .I_PSEL    (psel),
      .I_PENABLE (penable),
      .I_PWRITE  (pwrite),
      .I_PADDR   (paddr),
      .I_PWDATA  (pwdata),
      .O_PRDATA  (prdata),
      .O_PREADY  (pready),
      .O_PSLVERR (pslverr),
      .O_BUSY    (busy)
   );

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Masked register read and compare
   task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(nm, e, rd & m);
   endtask

   // Issue a command, then wait out any multi-cycle sequence
   task automatic cmd(input logic [3:0] op, input logic [7:0] opd);
      wr(`CIS_OFF_CMD, {16'h0000, opd, 4'h0, op});
      // A hang here is caught by the watchdog
      do begin
         @(posedge sys_clk);
      end while (busy !== 1'b0);
   endtask

   task automatic ld(input logic [31:0] ps, input logic [31:0] a, input logic [31:0] b);
      wr(`CIS_OFF_PS, ps);
      wr(`CIS_OFF_A, a);
      wr(`CIS_OFF_B, b);
   endtask

   task automatic mv(input logic [3:0] op, input logic [7:0] x, input logic [7:0] y,
                     input logic [7:0] n);
      wr(`CIS_OFF_X, {24'h0, x});
      wr(`CIS_OFF_Y, {24'h0, y});
      wr(`CIS_OFF_A, {24'h0, n});
      cmd(op, 8'h00);
   endtask

   task automatic mchk(input logic [7:0] a, input logic [7:0] e);
      wr(`CIS_OFF_MADDR, {24'h0, a});
      chk("mem", `CIS_OFF_MDATA, 32'hFF, {24'h0, e});
   endtask

   function automatic logic [8:0] add8(input logic [7:0] x, input logic [7:0] y);
      return {1'b0, x} + {1'b0, y};
   endfunction

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog: far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      test_done;
   end

   initial begin
      void'($urandom(82));
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      chk("ps_reset", `CIS_OFF_PS, 32'hFF, 32'h34);
      chk("unmapped", 8'h3C, 32'hFFFFFFFF, 32'h0);
      cmp("slverr", 32'h1, {31'h0, last_err});
      // Binary add; 99+01 would read 00 if decimal fix-up leaked in
      for (int i = 0; i < 8; i++) begin
         ra = (i == 0) ? 8'h99 : 8'($urandom);
         rb = (i == 0) ? 8'h01 : 8'($urandom);
         sum = add8(ra, rb);
         ld(32'h34, {24'h0, ra}, {24'h0, rb});
         cmd(cis_pkg::OP_ADC, 8'h00);
         chk("adc_bin", `CIS_OFF_A, 32'hFF, {24'h0, sum[7:0]});
         chk("adc_c", `CIS_OFF_PS, 32'h01, {31'h0, sum[8]});
      end
      // Decimal add: only carry moves, stale zero and negative kept; decimal subtract also sets zero
      ld(32'hBE, 32'h58, 32'h46);
      cmd(cis_pkg::OP_ADC, 8'h00);
      chk("dadc_a", `CIS_OFF_A, 32'hFF, 32'h04);
      chk("dadc_ps", `CIS_OFF_PS, 32'hFF, 32'hBF);
      ld(32'h7D, 32'h42, 32'h42);
      cmd(cis_pkg::OP_SBC, 8'h00);
      chk("dsbc_ps", `CIS_OFF_PS, 32'hFF, 32'h7F);
      // Source bytes straddle the 8-bit wrap point
      wr(`CIS_OFF_PS, 32'h34);
      for (int i = 0; i < 4; i++) begin
         wr(`CIS_OFF_MADDR, {24'h0, 8'(8'hFE + i)});
         wr(`CIS_OFF_MDATA, 32'(8'h11 * (i + 1)));
      end
      wr(`CIS_OFF_MADDR, 32'h50);
      wr(`CIS_OFF_MDATA, 32'h5A);
      mv(cis_pkg::OP_MVN, 8'hFE, 8'h40, 8'h03);
      chk("mv_cnt", `CIS_OFF_A, 32'hFF, 32'h0);
      for (int i = 0; i < 3; i++)
         mchk(8'(8'h40 + i), 8'(8'h11 * (i + 1)));
      mv(cis_pkg::OP_MVP, 8'h01, 8'h81, 8'h03);
      for (int i = 0; i < 3; i++)
         mchk(8'(8'h81 - i), 8'(8'h44 - 8'h11 * i));
      mv(cis_pkg::OP_MVN, 8'hFE, 8'h50, 8'h00);
      mchk(8'h50, 8'h5A);
      // Word load from an even, then an odd address
      for (int i = 0; i < 2; i++) begin
         wr(`CIS_OFF_X, 32'(8'h40 + i));
         cmd(cis_pkg::OP_LD16, 8'h00);
         chk("ld_cyc", `CIS_OFF_STAT, 32'hFFFF, 32'(1 + i));
         chk("ld_a", `CIS_OFF_A, 32'hFFFF, 32'h1100 * (i + 2) + 32'h11 * (i + 1));
      end
      // Break with a random second byte only sets I
      wr(`CIS_OFF_PS, 32'h30);
      cmd(cis_pkg::OP_BRK, 8'($urandom));
      chk("brk_ps", `CIS_OFF_PS, 32'hFF, 32'h34);
      chk("brk_a", `CIS_OFF_A, 32'hFFFF, 32'h3322);
      // Second command too soon after a long one waits on the queue
      repeat (2) wr(`CIS_OFF_CMD, {28'h0, cis_pkg::OP_BRAL});
      chk("q_stall", `CIS_OFF_STAT, 32'hFFFF, 32'h2);
      // Wide push and pull of A, status left alone; then a byte pull of A sets N
      wr(`CIS_OFF_S, 32'h01FF);
      ld(32'h14, 32'h8234, 32'h0);
      cmd(cis_pkg::OP_PSH, 8'h01);
      wr(`CIS_OFF_A, 32'h0);
      cmd(cis_pkg::OP_PUL, 8'h01);
      chk("pul_a", `CIS_OFF_A, 32'hFFFF, 32'h8234);
      chk("pul_ps", `CIS_OFF_PS, 32'hFF, 32'h14);
      ld(32'h34, 32'h80, 32'h0);
      cmd(cis_pkg::OP_PSH, 8'h01);
      wr(`CIS_OFF_A, 32'h0);
      cmd(cis_pkg::OP_PLA, 8'h00);
      chk("pla_ps", `CIS_OFF_PS, 32'hFF, 32'hB4);
      // Program bank saved but never restored
      // banks nonzero only with external fetch
      wr(`CIS_OFF_CFG, 32'h1);
      wr(`CIS_OFF_BANK, 32'h05);
      cmd(cis_pkg::OP_PSH, 8'h40);
      wr(`CIS_OFF_BANK, 32'h07);
      cmd(cis_pkg::OP_PUL, 8'h40);
      chk("bank", `CIS_OFF_BANK, 32'hFFFF, 32'h07);
      cmd(cis_pkg::OP_BRAL, 8'h00);
      chk("bra_far", `CIS_OFF_STAT, 32'h4FFFF, 32'h40004);
      wr(`CIS_OFF_BANK, 32'h0);
      wr(`CIS_OFF_CFG, 32'h3);
      cmd(cis_pkg::OP_BRAL, 8'h00);
      chk("bra_b0", `CIS_OFF_STAT, 32'h4FFFF, 32'h1);
      wr(`CIS_OFF_DPR, 32'h0100);
      cmd(cis_pkg::OP_DPOP, 8'h00);
      chk("dp_fast", `CIS_OFF_STAT, 32'h8FFFF, 32'h80001);
      wr(`CIS_OFF_DPR, 32'h0101);
      cmd(cis_pkg::OP_DPOP, 8'h00);
      chk("dp_slow", `CIS_OFF_STAT, 32'h8FFFF, 32'h2);
      // Multi pull restores a zero low byte but not the saving
      wr(`CIS_OFF_S, 32'h01FF);
      wr(`CIS_OFF_DPR, 32'h0100);
      cmd(cis_pkg::OP_PSH, 8'h10);
      wr(`CIS_OFF_DPR, 32'h0101);
      cmd(cis_pkg::OP_PUL, 8'h10);
      chk("pul_dpr", `CIS_OFF_DPR, 32'hFFFF, 32'h0100);
      chk("pul_fast", `CIS_OFF_STAT, 32'h80000, 32'h0);
      wr(`CIS_OFF_S, 32'h01FD);
      cmd(cis_pkg::OP_PLD, 8'h00);
      chk("pld_fast", `CIS_OFF_STAT, 32'h80000, 32'h80000);
      wr(`CIS_OFF_PS, 32'h14);
      chk("imm_m", `CIS_OFF_STAT, 32'h30000, 32'h10000);
      wr(`CIS_OFF_PS, 32'h24);
      chk("imm_x", `CIS_OFF_STAT, 32'h30000, 32'h20000);
      test_done;
   end
endmodule
